// *** design/csfr_bank.sv ***
// Purpose: core and first two peripheral banks of the sfr file, AXI4-Lite
// Assumes: core_clk 125 MHz, reset pins asynchronous to core_clk
// Notes:   peripheral functions behind the registers are not modelled
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module csfr_bank (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 master_clear_reset,
  input  wire logic                 watchdog_reset,
  input  wire logic                 brown_out_reset,
  input  wire csfr_pkg::csfr_port_t port_in,
  output wire csfr_pkg::csfr_port_t port_out,
  output csfr_pkg::csfr_port_t      port_oe,
  output wire logic [15:0]          program_counter,
  output logic                      irq
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [30:0]          raw;
  logic [30:0]          s1_q;
  logic [30:0]          s2_q;
  logic [30:0]          s3_q;
  logic [30:0]          filt_q;
  logic [30:0]          filt_d;
  logic [30:0]          agree;
  logic [2:0]           evt_lvl;
  logic [2:0]           evt_prev_q;
  logic [2:0]           evt_rise;
  logic                 sync_rst;
  csfr_pkg::csfr_port_t pins;

  // resets and port pins come from outside core_clk
  assign raw      = {brown_out_reset, watchdog_reset, master_clear_reset,
                     port_in};
  assign agree    = ~(s2_q ^ s3_q);
  assign filt_d   = (agree & s3_q) | (~agree & filt_q);
  assign evt_lvl  = filt_q[30:28];
  assign pins     = filt_q[27:0];
  assign evt_rise = evt_lvl & ~evt_prev_q;
  assign sync_rst = |evt_lvl;

  // three stages, a change counts once stages two and three agree
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q       <= '0;
      s2_q       <= '0;
      s3_q       <= '0;
      filt_q     <= '0;
      evt_prev_q <= '0;
    end else begin
      s1_q       <= raw;
      s2_q       <= s1_q;
      s3_q       <= s2_q;
      filt_q     <= filt_d;
      evt_prev_q <= evt_lvl;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic                aw_held_q;
  logic                aw_held_d;
  logic [5:0]          aw_idx_q;
  logic                w_held_q;
  logic                w_held_d;
  logic [7:0]          w_byte_q;
  logic                w_lane_q;
  logic                bvalid_d;
  logic                aw_hs;
  logic                w_hs;
  logic                wr_fire;
  logic                wr_on;
  csfr_pkg::csfr_loc_t wr_tgt;
  csfr_pkg::csfr_attr_t wr_attr;
  logic [7:0]          file_q [0:31];
  logic [7:0]          file_d [0:31];

  // address and data are taken in either order, one write at a time
  assign aw_hs     = s_axi_awvalid & s_axi_awready;
  assign w_hs      = s_axi_wvalid & s_axi_wready;
  assign wr_fire   = aw_held_q & w_held_q & ~s_axi_bvalid;
  assign aw_held_d = aw_hs | (aw_held_q & ~wr_fire);
  assign w_held_d  = w_hs | (w_held_q & ~wr_fire);
  assign bvalid_d  = wr_fire | (s_axi_bvalid & ~s_axi_bready);
  assign wr_on     = wr_fire & w_lane_q;
  assign wr_tgt    = csfr_pkg::csfr_target(aw_idx_q,
                       file_q[csfr_pkg::LOC_BANKSEL][3:0],
                       file_q[csfr_pkg::LOC_PTR0], file_q[csfr_pkg::LOC_PTR1]);
  assign wr_attr   = csfr_pkg::csfr_attr(wr_tgt.loc);

  // only byte lane 0 carries register data
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      aw_idx_q      <= '0;
      w_byte_q      <= '0;
      w_lane_q      <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      aw_held_q     <= aw_held_d;
      w_held_q      <= w_held_d;
      aw_idx_q      <= aw_hs ? s_axi_awaddr[7:2] : aw_idx_q;
      w_byte_q      <= w_hs ? s_axi_wdata[7:0] : w_byte_q;
      w_lane_q      <= w_hs ? s_axi_wstrb[0] : w_lane_q;
      s_axi_bvalid  <= bvalid_d;
      s_axi_awready <= ~aw_held_d & ~bvalid_d;
      s_axi_wready  <= ~w_held_d & ~bvalid_d;
    end
  end

  assign s_axi_bresp = csfr_pkg::AXI_OKAY;

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic                 ar_hs;
  logic                 rd_ph_q;
  logic                 rvalid_d;
  logic [5:0]           rd_idx_q;
  csfr_pkg::csfr_loc_t  rd_tgt;
  csfr_pkg::csfr_loc_t  rd_tgt_q;
  csfr_pkg::csfr_attr_t rd_attr;
  logic [7:0]           mem_rdata;
  logic [7:0]           rd_file;
  logic [7:0]           rd_byte;
  logic [2:0]           evt_status_q;
  logic [2:0]           evt_mask_q;
  logic                 peif;

  assign ar_hs    = s_axi_arvalid & s_axi_arready;
  assign rvalid_d = rd_ph_q | (s_axi_rvalid & ~s_axi_rready);
  assign rd_tgt   = csfr_pkg::csfr_target(s_axi_araddr[7:2],
                      file_q[csfr_pkg::LOC_BANKSEL][3:0],
                      file_q[csfr_pkg::LOC_PTR0], file_q[csfr_pkg::LOC_PTR1]);
  assign rd_attr  = csfr_pkg::csfr_attr(rd_tgt_q.loc);
  assign peif     = |(file_q[csfr_pkg::LOC_PERIPHERAL_INTERRUPT_FLAGS_1] & file_q[csfr_pkg::LOC_PERIPHERAL_INTERRUPT_ENABLES_1]);

  // port pin locations read the pins, the core flag byte shows peif
  always_comb begin
    rd_file = file_q[rd_tgt_q.loc];
    unique case (rd_tgt_q.loc)
      csfr_pkg::LOC_PB_PINS: rd_file = pins.b;
      csfr_pkg::LOC_PC_PINS: rd_file = pins.c;
      csfr_pkg::LOC_PD_PINS: rd_file = pins.d;
      csfr_pkg::LOC_PE_PINS: rd_file = {4'h0, pins.e};
      csfr_pkg::LOC_INTFL:   rd_file[csfr_pkg::INT_PEIF] = peif;
      default:               rd_file = file_q[rd_tgt_q.loc];
    endcase
  end

  always_comb begin
    rd_byte = 8'h00;
    if (rd_tgt_q.hit) begin
      rd_byte = (rd_attr.mem ? mem_rdata : rd_file) & rd_attr.impl;
    end else if (rd_idx_q == csfr_pkg::IDX_EVT_STATUS) begin
      rd_byte = {5'h00, evt_status_q};
    end else if (rd_idx_q == csfr_pkg::IDX_EVT_MASK) begin
      rd_byte = {5'h00, evt_mask_q};
    end
  end

  // answer one edge after the address is taken (store latency)
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ph_q       <= 1'b0;
      rd_idx_q      <= '0;
      rd_tgt_q      <= '0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_arready <= 1'b0;
    end else begin
      rd_ph_q       <= ar_hs;
      rd_idx_q      <= ar_hs ? s_axi_araddr[7:2] : rd_idx_q;
      rd_tgt_q      <= ar_hs ? rd_tgt : rd_tgt_q;
      s_axi_rvalid  <= rvalid_d;
      s_axi_rdata   <= rd_ph_q ? {24'h0000_00, rd_byte} : s_axi_rdata;
      s_axi_arready <= ~(ar_hs | rd_ph_q | rvalid_d);
    end
  end

  assign s_axi_rresp = csfr_pkg::AXI_OKAY;

  // data-only bytes live in the store
  csfr_store u_store (
    .core_clk (core_clk),
    .we       (wr_on & wr_tgt.hit & wr_attr.mem & (|wr_attr.wmask)),
    .waddr    (wr_tgt.loc),
    .wdata    (w_byte_q),
    .re       (ar_hs),
    .raddr    (rd_tgt.loc),
    .rdata    (mem_rdata)
  );

  // ----------------------------------------------------------------
  // program counter upper byte
  // ----------------------------------------------------------------
  logic [7:0] pc_high_q;
  logic pcl_wr;
  logic pcl_rd;

  assign pcl_wr = wr_on & wr_tgt.hit & (wr_tgt.loc == csfr_pkg::LOC_PCL);
  assign pcl_rd = rd_ph_q & rd_tgt_q.hit & (rd_tgt_q.loc == csfr_pkg::LOC_PCL);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_high_q <= csfr_pkg::PC_HIGH_RST;
    end else if (sync_rst) begin
      pc_high_q <= csfr_pkg::PC_HIGH_RST;
    end else if (pcl_wr) begin
      pc_high_q <= file_q[csfr_pkg::LOC_PCLATCH];
    end
  end

  assign program_counter = {pc_high_q, file_q[csfr_pkg::LOC_PCL]};

  // ----------------------------------------------------------------
  // register file next state
  // ----------------------------------------------------------------
  csfr_pkg::csfr_attr_t a_v;
  logic [7:0]           d_v;

  always_comb begin
    a_v = '0;
    d_v = '0;
    for (int i = 0; i < csfr_pkg::LOC_N; i++) begin
      a_v = csfr_pkg::csfr_attr(5'(i));
      d_v = file_q[i];
      if (sync_rst) begin
        d_v = (d_v & a_v.keep) | a_v.rstv;
      end else if (wr_on && wr_tgt.hit && wr_tgt.loc == 5'(i)) begin
        d_v = (d_v & ~a_v.wmask) | (w_byte_q & a_v.wmask);
      end else if (pcl_rd && 5'(i) == csfr_pkg::LOC_PCLATCH) begin
        d_v = pc_high_q;
      end
      file_d[i] = a_v.mem ? 8'h00 : (d_v & a_v.impl);
    end
    if (evt_lvl[csfr_pkg::EVT_BOR]) begin
      file_d[csfr_pkg::LOC_CPUST][csfr_pkg::CPU_TO]   = 1'b1;
      file_d[csfr_pkg::LOC_CPUST][csfr_pkg::CPU_PD]   = 1'b1;
      file_d[csfr_pkg::LOC_CPUST][csfr_pkg::CPU_BORF] = 1'b0;
      file_d[csfr_pkg::LOC_PCLATCH]                   = 8'h00;
    end else if (evt_lvl[csfr_pkg::EVT_WDT]) begin
      file_d[csfr_pkg::LOC_CPUST][csfr_pkg::CPU_TO]   = 1'b0;
      file_d[csfr_pkg::LOC_CPUST][csfr_pkg::CPU_PD]   = 1'b1;
    end
    // master clear keeps TO and PD through the keep mask
  end

  for (genvar g = 0; g < csfr_pkg::LOC_N; g++) begin : g_file
    localparam csfr_pkg::csfr_attr_t A = csfr_pkg::csfr_attr(5'(g));
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        file_q[g] <= A.porv;
      end else begin
        file_q[g] <= file_d[g];
      end
    end
  end

  assign port_out = {file_q[csfr_pkg::LOC_PB_PINS], file_q[csfr_pkg::LOC_PC_PINS],
                     file_q[csfr_pkg::LOC_PD_PINS], file_q[csfr_pkg::LOC_PE_PINS][3:0]};

  // ----------------------------------------------------------------
  // pin drivers and reset events
  // ----------------------------------------------------------------
  logic [2:0] evt_status_d;
  logic [2:0] evt_mask_d;
  logic       wr_st;
  logic       wr_mk;

  assign wr_st = wr_on & (aw_idx_q == csfr_pkg::IDX_EVT_STATUS);
  assign wr_mk = wr_on & (aw_idx_q == csfr_pkg::IDX_EVT_MASK);
  // a new event beats a write-one clear in the same cycle
  assign evt_status_d = (evt_status_q & ~(wr_st ? w_byte_q[2:0] : 3'h0)) | evt_rise;
  assign evt_mask_d   = wr_mk ? w_byte_q[2:0] : evt_mask_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_oe      <= '0;
      evt_status_q <= '0;
      evt_mask_q   <= '0;
      irq          <= 1'b0;
    end else begin
      port_oe      <= ~{file_d[csfr_pkg::LOC_PB_DIR], file_d[csfr_pkg::LOC_PC_DIR],
                        file_d[csfr_pkg::LOC_PD_DIR], file_d[csfr_pkg::LOC_PE_DIR][3:0]};
      evt_status_q <= evt_status_d;
      evt_mask_q   <= evt_mask_d;
      irq          <= |(evt_status_d & evt_mask_d);
    end
  end

endmodule
`default_nettype wire

// *** design/csfr_pkg.sv ***
// Purpose: constants, types and decode helpers of the core sfr bank
// Assumes: file addresses 00h-17h, banked window 10h-17h
// Notes:   per-location attributes drive one generic register model
package csfr_pkg;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       hit;
    logic [4:0] loc;
  } csfr_loc_t;

  typedef struct packed {
    logic [7:0] b;
    logic [7:0] c;
    logic [7:0] d;
    logic [3:0] e;
  } csfr_port_t;

  // impl: readable bits, wmask: software writable, keep: kept on
  // a synchronous reset, rstv: synchronous reset value, porv: power-on
  typedef struct packed {
    logic       mem;
    logic [7:0] impl;
    logic [7:0] wmask;
    logic [7:0] keep;
    logic [7:0] rstv;
    logic [7:0] porv;
  } csfr_attr_t;

  // ----------------------------------------------------------------
  // locations (unbanked 00-0f, bank 0 at 10-17, bank 1 at 18-1f)
  // ----------------------------------------------------------------
  localparam logic [4:0] LOC_WIN0    = 5'h00;
  localparam logic [4:0] LOC_PTR0    = 5'h01;
  localparam logic [4:0] LOC_PCL     = 5'h02;
  localparam logic [4:0] LOC_PCLATCH = 5'h03;
  localparam logic [4:0] LOC_CPUST   = 5'h06;
  localparam logic [4:0] LOC_INTFL   = 5'h07;
  localparam logic [4:0] LOC_WIN1    = 5'h08;
  localparam logic [4:0] LOC_PTR1    = 5'h09;
  localparam logic [4:0] LOC_BANKSEL = 5'h0f;
  localparam logic [4:0] LOC_PB_PINS = 5'h12;
  localparam logic [4:0] LOC_PC_DIR  = 5'h18;
  localparam logic [4:0] LOC_PC_PINS = 5'h19;
  localparam logic [4:0] LOC_PD_DIR  = 5'h1a;
  localparam logic [4:0] LOC_PD_PINS = 5'h1b;
  localparam logic [4:0] LOC_PE_DIR  = 5'h1c;
  localparam logic [4:0] LOC_PE_PINS = 5'h1d;
  localparam logic [4:0] LOC_PERIPHERAL_INTERRUPT_FLAGS_1    = 5'h1e;
  localparam logic [4:0] LOC_PERIPHERAL_INTERRUPT_ENABLES_1    = 5'h1f;
  localparam logic [4:0] LOC_PB_DIR  = 5'h11;
  localparam int         LOC_N       = 32;

  localparam logic [7:0] FILE_BANKED_LO = 8'h10;
  localparam logic [7:0] FILE_BANKED_HI = 8'h17;
  localparam logic [3:0] BANK_0         = 4'h0;
  localparam logic [3:0] BANK_1         = 4'h1;

  // bus word index = byte address / 4
  localparam logic [5:0] IDX_FILE_END   = 6'h18;
  localparam logic [5:0] IDX_EVT_STATUS = 6'h20;
  localparam logic [5:0] IDX_EVT_MASK   = 6'h21;
  localparam logic [1:0] AXI_OKAY       = 2'b00;

  // bit positions
  localparam int EVT_MASTER_CLEAR_RESET = 0;
  localparam int EVT_WDT  = 1;
  localparam int EVT_BOR  = 2;
  localparam int CPU_TO   = 3;
  localparam int CPU_PD   = 2;
  localparam int CPU_BORF = 0;
  localparam int INT_PEIF = 7;
  localparam logic [7:0] PC_HIGH_RST = 8'h00;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic csfr_loc_t csfr_resolve(input logic [7:0] addr,
                                             input logic [3:0] bsel);
    csfr_loc_t r;
    r = '0;
    if (addr < FILE_BANKED_LO) begin
      r = '{1'b1, addr[4:0]};
    end else if (addr <= FILE_BANKED_HI && bsel == BANK_0) begin
      r = '{1'b1, {2'b10, addr[2:0]}};
    end else if (addr <= FILE_BANKED_HI && bsel == BANK_1) begin
      r = '{1'b1, {2'b11, addr[2:0]}};
    end
    return r;
  endfunction

  // bus index to location, following the two indirect windows
  function automatic csfr_loc_t csfr_target(input logic [5:0] idx,
                                            input logic [3:0] bsel,
                                            input logic [7:0] ptr0,
                                            input logic [7:0] ptr1);
    csfr_loc_t r;
    r = '0;
    if (idx < IDX_FILE_END) begin
      r = csfr_resolve({2'b00, idx}, bsel);
    end
    if (r.hit && r.loc == LOC_WIN0) begin
      r = csfr_resolve(ptr0, bsel);
    end else if (r.hit && r.loc == LOC_WIN1) begin
      r = csfr_resolve(ptr1, bsel);
    end
    if (r.loc == LOC_WIN0 || r.loc == LOC_WIN1) begin
      r.hit = 1'b0;
    end
    return r;
  endfunction

  function automatic csfr_attr_t csfr_attr(input logic [4:0] loc);
    csfr_attr_t a;
    a = '0;
    unique case (loc)
      5'h01, 5'h09: a = '{1'b0, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00};
      5'h02:        a = '{1'b0, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
      5'h03:        a = '{1'b0, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00};
      5'h04:        a = '{1'b0, 8'hff, 8'hff, 8'h0f, 8'hf0, 8'hf0};
      5'h05:        a = '{1'b0, 8'hfe, 8'hfe, 8'h00, 8'h00, 8'h00};
      5'h06:        a = '{1'b0, 8'h3f, 8'h13, 8'h0f, 8'h30, 8'h3c};
      5'h07:        a = '{1'b0, 8'hff, 8'h7f, 8'h00, 8'h00, 8'h00};
      5'h0a, 5'h0b,
      5'h0c:        a = '{1'b1, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00};
      5'h0d, 5'h0e, 5'h0f,
      5'h17, 5'h1f: a = '{1'b0, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
      5'h10:        a = '{1'b0, 8'hbf, 8'hbf, 8'h33, 8'h0c, 8'h0c};
      5'h11, 5'h18,
      5'h1a:        a = '{1'b0, 8'hff, 8'hff, 8'h00, 8'hff, 8'hff};
      5'h12, 5'h19,
      5'h1b:        a = '{1'b0, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00};
      5'h13:        a = '{1'b0, 8'hf7, 8'hf1, 8'h01, 8'h00, 8'h00};
      5'h14:        a = '{1'b1, 8'hff, 8'h00, 8'hff, 8'h00, 8'h00};
      5'h15:        a = '{1'b0, 8'hf3, 8'hf1, 8'h01, 8'h02, 8'h02};
      5'h16:        a = '{1'b1, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00};
      5'h1c:        a = '{1'b0, 8'h0f, 8'h0f, 8'h00, 8'h0f, 8'h0f};
      5'h1d:        a = '{1'b0, 8'h0f, 8'h0f, 8'h0f, 8'h00, 8'h00};
      5'h1e:        a = '{1'b0, 8'hff, 8'hff, 8'h80, 8'h02, 8'h02};
      default:      a = '0;
    endcase
    return a;
  endfunction

endpackage

// *** design/csfr_store.sv ***
// Purpose: plain byte store for data-only file locations
// Assumes: one write and one read port, same clock
// Notes:   no reset, contents survive every reset; read data registered
`timescale 1ns/1ps
`default_nettype none
module csfr_store (
  input  wire logic       core_clk,
  input  wire logic       we,
  input  wire logic [4:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic       re,
  input  wire logic [4:0] raddr,
  output logic      [7:0] rdata
);

  logic [7:0] mem_q [0:31];

  // write port
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  // registered read, held between reads
  always_ff @(posedge core_clk) begin
    if (re) begin
      rdata <= mem_q[raddr];
    end
  end

endmodule
`default_nettype wire

// *** tb/csfr_bank_monitor.sv ***
// Purpose: port-level checks of the core sfr bank
// Assumes: one clock, rst_n asynchronous and active low
// Notes:   attached to csfr_bank by the bind at the foot
`timescale 1ns/1ps
`default_nettype none
module csfr_bank_monitor (
  input wire logic                 core_clk,
  input wire logic                 rst_n,
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic [1:0]           s_axi_bresp,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic [31:0]          s_axi_rdata,
  input wire logic [1:0]           s_axi_rresp,
  input wire logic                 s_axi_rvalid,
  input wire logic                 master_clear_reset,
  input wire logic                 watchdog_reset,
  input wire logic                 brown_out_reset,
  input wire csfr_pkg::csfr_port_t port_oe,
  input wire logic [15:0]          program_counter,
  input wire logic                 irq
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // both halves of a write taken at one edge, read address taken
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // a pin reset held long enough to pass the synchroniser
  sequence s_pin_held;
    (master_clear_reset || watchdog_reset || brown_out_reset) [*8];
  endsequence

  a_wr_answer: assert property (s_wr_take |-> ##[1:3] s_axi_bvalid)
    else $error("write not answered in time");
  a_rd_answer: assert property (s_rd_take |-> ##[1:4] s_axi_rvalid)
    else $error("read not answered in time");
  a_bresp_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00)
    else $error("write response not okay");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("unused read bits not zero");
  a_rresp_okay: assert property (s_axi_rvalid |-> s_axi_rresp == 2'b00)
    else $error("read response not okay");
  a_oe_released: assert property ($rose(rst_n) |-> (port_oe == '0) [*4])
    else $error("port driven after reset");
  a_pin_rst_inputs: assert property (s_pin_held |-> port_oe == '0)
    else $error("port driven during pin reset");
  a_pc_cleared: assert property ($rose(rst_n) |-> program_counter == 16'h0000)
    else $error("program counter not cleared");
  a_pc_upper_src: assert property ($changed(program_counter[15:8]) |->
    s_axi_bvalid || $past(s_axi_bvalid) || program_counter[15:8] == 8'h00)
    else $error("pc upper byte moved without a write");
  a_irq_quiet: assert property ($rose(rst_n) |-> !irq [*4])
    else $error("interrupt raised with mask clear");
endmodule

bind csfr_bank csfr_bank_monitor u_mon (
  .core_clk(core_clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .master_clear_reset(master_clear_reset),
  .watchdog_reset(watchdog_reset), .brown_out_reset(brown_out_reset), .port_oe(port_oe),
  .program_counter(program_counter), .irq(irq));
`default_nettype wire

// *** tb/csfr_tb.sv ***
// Purpose: register-level tests of the core sfr bank over AXI4-Lite
// Assumes: 125 MHz core_clk, pin resets held well past the synchroniser
// Notes:   expected values come from the reset table and reset causes
`timescale 1ns/1ps
`default_nettype none
`define CMP(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: %h not %h", $time, g, e); end end
module testbench;
  // ----------------------------------------------------------------
  // signals and dut
  // ----------------------------------------------------------------
  logic                 core_clk = 0;
  logic                 rst_n = 0;
  logic [7:0]           s_axi_awaddr = '0;
  logic [7:0]           s_axi_araddr = '0;
  logic [31:0]          s_axi_wdata = '0;
  logic [31:0]          s_axi_rdata;
  logic                 s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic                 s_axi_arvalid = 0, s_axi_rready = 0;
  logic                 s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [2:0]           pins = '0;
  csfr_pkg::csfr_port_t port_in = '{8'h11, 8'h3c, 8'h5a, 4'h9};
  csfr_pkg::csfr_port_t port_oe, port_out;
  logic [15:0]          program_counter;
  logic [7:0]           v;
  int                   num_errors = 0, checks = 0, cycles = 0;

  csfr_bank dut (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .master_clear_reset(pins[0]), .watchdog_reset(pins[1]), .brown_out_reset(pins[2]),
    .port_in(port_in), .port_out(port_out), .port_oe(port_oe), .program_counter(program_counter), .irq(irq));

  // clock, and a ceiling well above the few hundred cycles needed
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic a, w;
    a = 1;
    w = 1;
    @(posedge core_clk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (a && s_axi_awready) begin
        a = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 0;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(s_axi_bvalid && !a && !w));
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] i, output logic [7:0] d);
    logic a;
    a = 1;
    @(posedge core_clk);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (a && s_axi_arready) begin
        a = 0;
        s_axi_arvalid <= 1'b0;
      end
    end while (!(s_axi_rvalid && !a));
    d = s_axi_rdata[7:0];
    s_axi_rready <= 1'b0;
  endtask

  task automatic chk(input logic [5:0] i, input logic [7:0] e);
    rd(i, v);
    `CMP(v, e)
  endtask

  // pin reset k held long past the synchroniser, then settled
  task automatic pin(input int k);
    @(posedge core_clk);
    pins[k] <= 1'b1;
    repeat (12) @(posedge core_clk);
    pins <= '0;
    repeat (12) @(posedge core_clk);
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk(6'h11, 8'hff);
    chk(6'h06, 8'h3c);
    chk(6'h12, 8'h11);
    chk(6'h18, 8'h00);
    `CMP(port_oe, 28'h000_0000)
    $display("test power-on values done");
    wr(6'h0f, 8'h01);
    chk(6'h12, 8'hff);
    chk(6'h14, 8'h0f);
    wr(6'h14, 8'hff);
    chk(6'h14, 8'h0f);
    chk(6'h11, 8'h3c);
    wr(6'h01, 8'h12);
    chk(6'h00, 8'hff);
    wr(6'h12, 8'h0f);
    chk(6'h12, 8'h0f);
    `CMP(port_oe.d, 8'hf0)
    wr(6'h13, 8'h96);
    `CMP(port_out.d, 8'h96)
    $display("test banking and direction done");
    wr(6'h03, 8'h5a);
    wr(6'h02, 8'h34);
    `CMP(program_counter, 16'h5a34)
    wr(6'h03, 8'h00);
    chk(6'h02, 8'h34);
    chk(6'h03, 8'h5a);
    $display("test program counter done");
    wr(6'h0a, 8'ha5);
    pin(1);
    chk(6'h06, 8'h34);
    chk(6'h0a, 8'ha5);
    chk(6'h03, 8'h5a);
    chk(6'h0f, 8'h00);
    wr(6'h0f, 8'h01);
    chk(6'h12, 8'hff);
    `CMP(port_oe, 28'h000_0000)
    pin(0);
    chk(6'h06, 8'h34);
    pin(2);
    rd(6'h06, v);
    `CMP(v & 8'h3d, 8'h3c)
    $display("test reset causes done");
    chk(6'h20, 8'h07);
    `CMP(irq, 1'b0)
    wr(6'h21, 8'h02);
    repeat (3) @(posedge core_clk);
    `CMP(irq, 1'b1)
    wr(6'h20, 8'h02);
    chk(6'h20, 8'h05);
    `CMP(irq, 1'b0)
    $display("test interrupt done");
    conclude();
  end
endmodule
`default_nettype wire
